// ---- core/cpu_core_register_file.sv ----
// Programmer-visible register set and stack sequencer of the CPU core
`timescale 1ns/1ps
module cpu_core_register_file
    import cpu_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire reg_wr_s reg_wr,
    input wire alu_s alu,
    input wire flag_cmd_s flag_cmd,
    input wire cmd_e cmd,
    input wire logic prefix_second,
    input wire logic instr_done,
    input wire logic instr_boundary,
    input wire logic irq_req,
    input wire logic br_req,
    input wire flag_sel_e br_flag,
    input wire logic br_if_set,
    input wire logic [7:0] stk_rdata,
    output logic [7:0] a_q,
    output logic [7:0] x_q,
    output logic [7:0] y_q,
    output logic [7:0] index_q,
    output logic [15:0] pc_q,
    output logic [7:0] cc_q,
    output logic [15:0] sp_q,
    output logic [15:0] stk_addr_q,
    output logic [7:0] stk_wdata_q,
    output logic stk_we_q,
    output logic stk_re_q,
    output logic busy_q,
    output logic br_valid_q,
    output logic br_take_q,
    output logic irq_take_q,
    output logic pending_q
);

    // ========================================================
    // Frame layout helpers
    function automatic logic [2:0] len_of(kind_e k);
        case (k)
            k_irq: len_of = IRQ_FRAME;
            k_call: len_of = CALL_FRAME;
            default: len_of = CC_FRAME;
        endcase
    endfunction

    // Push order; pops walk it backwards
    function automatic byte_sel_e sel_of(kind_e k, logic [2:0] i);
        if (k == k_cc)
            sel_of = b_cc;
        else
            case (i)
                3'h0: sel_of = b_pcl;
                3'h1: sel_of = b_pch;
                3'h2: sel_of = b_x;
                3'h3: sel_of = b_a;
                default: sel_of = b_cc;
            endcase
    endfunction

    typedef enum logic [1:0] {st_idle, st_push, st_pop_rd, st_pop_cap}
        state_e;

    state_e state_q;
    kind_e kind_q;
    logic [2:0] step_q;
    logic [6:0] sp_lo_q;
    logic prefix_q;
    logic h_q, i_q, n_q, z_q, c_q;
    logic idle, last, push_last, pop_last, cap_en, irq_go, cap_cc;
    logic [2:0] len;
    byte_sel_e push_sel, cap_sel;
    logic [7:0] push_val;
    logic [4:0] nib_sum;

    // ========================================================
    // Sequencer decode
    always_comb
    begin
        len = len_of(kind_q);
        idle = state_q == st_idle;
        last = step_q == 3'(len - 3'h1);
        push_last = state_q == st_push && last;
        pop_last = state_q == st_pop_cap && last;
        cap_en = state_q == st_pop_cap;
        push_sel = sel_of(kind_q, step_q);
        cap_sel = sel_of(kind_q, 3'(len - 3'h1 - step_q));
        cap_cc = cap_en && cap_sel == b_cc;
        irq_go = idle && instr_boundary && pending_q && !i_q
            && cmd == cmd_none;
    end

    // Byte offered to the stack on each push step
    always_comb
    begin
        case (push_sel)
            b_pcl: push_val = pc_q[7:0];
            b_pch: push_val = pc_q[15:8];
            b_x: push_val = x_q;
            b_a: push_val = a_q;
            default: push_val = cc_q;
        endcase
    end

    // ========================================================
    // Stack frame sequencer; commands are ignored while busy
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_q <= st_idle;
            kind_q <= k_cc;
            step_q <= 3'h0;
            busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                st_idle:
                begin
                    step_q <= 3'h0;
                    if (irq_go || cmd == cmd_trap)
                    begin
                        kind_q <= k_irq;
                        state_q <= st_push;
                        busy_q <= 1'b1;
                    end
                    else if (cmd != cmd_none)
                    begin
                        busy_q <= 1'b1;
                        case (cmd)
                            cmd_call: kind_q <= k_call;
                            cmd_ret: kind_q <= k_call;
                            cmd_interrupt_return_instruction: kind_q <= k_irq;
                            default: kind_q <= k_cc;
                        endcase
                        if (cmd == cmd_call || cmd == cmd_push_cc)
                            state_q <= st_push;
                        else
                            state_q <= st_pop_rd;
                    end
                end
                st_push:
                begin
                    step_q <= 3'(step_q + 3'h1);
                    if (last)
                    begin
                        state_q <= st_idle;
                        busy_q <= 1'b0;
                    end
                end
                st_pop_rd:
                    state_q <= st_pop_cap;
                st_pop_cap:
                begin
                    step_q <= 3'(step_q + 3'h1);
                    if (last)
                    begin
                        state_q <= st_idle;
                        busy_q <= 1'b0;
                    end
                    else
                        state_q <= st_pop_rd;
                end
                default:
                begin
                    state_q <= st_idle;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // Stack pointer: 7-bit counter wraps with no overflow flag
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            sp_lo_q <= SP_LOW_RESET;
        else if (state_q == st_push)
            sp_lo_q <= 7'(sp_lo_q - 7'h1);
        else if (state_q == st_pop_rd)
            sp_lo_q <= 7'(sp_lo_q + 7'h1);
        else if (idle && flag_cmd.reset_sp)
            sp_lo_q <= SP_LOW_RESET;
        else if (idle && reg_wr.sp_en)
            sp_lo_q <= reg_wr.data[6:0];
    end

    // Only seven bits are stored; the rest is wired constant
    assign sp_q = {SP_UPPER, sp_lo_q};

    // Stack memory port; read data is taken while stk_re_q is high
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            stk_we_q <= 1'b0;
            stk_re_q <= 1'b0;
            stk_addr_q <= 16'h0000;
            stk_wdata_q <= 8'h00;
        end
        else
        begin
            stk_we_q <= state_q == st_push;
            stk_re_q <= state_q == st_pop_rd;
            if (state_q == st_push)
            begin
                stk_addr_q <= sp_q;
                stk_wdata_q <= push_val;
            end
            else if (state_q == st_pop_rd)
                stk_addr_q <= {SP_UPPER, 7'(sp_lo_q + 7'h1)};
        end
    end

    // ========================================================
    // Data registers; outside writes are dropped while a frame runs
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            a_q <= A_RESET;
        else if (cap_en && cap_sel == b_a)
            a_q <= stk_rdata;
        else if (idle && reg_wr.a_en)
            a_q <= reg_wr.data;
    end

    // Index writes follow the prefix; frames skip the second one
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            x_q <= X_RESET;
            y_q <= Y_RESET;
        end
        else if (cap_en && cap_sel == b_x)
            x_q <= stk_rdata;
        else if (idle && reg_wr.idx_en)
        begin
            if (prefix_q)
                y_q <= reg_wr.data;
            else
                x_q <= reg_wr.data;
        end
    end

    // Prefix lasts one instruction; a new prefix beats the end mark
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            prefix_q <= 1'b0;
        else if (prefix_second)
            prefix_q <= 1'b1;
        else if (instr_done)
            prefix_q <= 1'b0;
    end

    // Address index lags the index registers by one cycle
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            index_q <= X_RESET;
        else
            index_q <= prefix_q ? y_q : x_q;
    end

    // Program counter, restored byte-wise from the stack
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            pc_q <= PC_RESET;
        else if (cap_en && cap_sel == b_pcl)
            pc_q[7:0] <= stk_rdata;
        else if (cap_en && cap_sel == b_pch)
            pc_q[15:8] <= stk_rdata;
        else if (idle && reg_wr.pc_en)
            pc_q <= reg_wr.pc;
        else if (idle && reg_wr.pc_inc)
            pc_q <= 16'(pc_q + 16'h0001);
    end

    // ========================================================
    // Condition flags
    assign nib_sum = {1'b0, alu.opnd_a[3:0]} + {1'b0, alu.opnd_b[3:0]}
        + {4'h0, alu.with_carry & c_q};

    // Later statements win, so mask entry/return override the rest
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            h_q <= FLAG_RESET;
            i_q <= MASK_RESET;
            n_q <= FLAG_RESET;
            z_q <= FLAG_RESET;
            c_q <= FLAG_RESET;
        end
        else
        begin
            if (cap_cc)
            begin
                h_q <= stk_rdata[CC_H];
                i_q <= stk_rdata[CC_I];
                n_q <= stk_rdata[CC_N];
                z_q <= stk_rdata[CC_Z];
                c_q <= stk_rdata[CC_C];
            end
            else if (idle)
            begin
                if (alu.valid)
                begin
                    n_q <= alu.result[7];
                    z_q <= alu.result == 8'h00;
                    if (alu.is_add)
                        h_q <= nib_sum[4];
                    if (alu.upd_c)
                        c_q <= alu.carry;
                end
                if (flag_cmd.set_carry)
                    c_q <= 1'b1;
                if (flag_cmd.clear_carry)
                    c_q <= 1'b0;
                if (flag_cmd.set_mask)
                    i_q <= 1'b1;
                if (flag_cmd.reset_mask)
                    i_q <= 1'b0;
            end
            if (push_last && kind_q == k_irq)
                i_q <= 1'b1;
            if (pop_last && kind_q == k_irq)
                i_q <= 1'b0;
        end
    end

    assign cc_q = {CC_FIXED, h_q, i_q, n_q, z_q, c_q};

    // ========================================================
    // Pending request latch; a new request beats the clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pending_q <= 1'b0;
            irq_take_q <= 1'b0;
        end
        else
        begin
            pending_q <= irq_req | (pending_q & ~irq_go);
            irq_take_q <= irq_go;
        end
    end

    // Branch condition evaluation
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            br_valid_q <= 1'b0;
            br_take_q <= 1'b0;
        end
        else
        begin
            br_valid_q <= br_req;
            case (br_flag)
                fl_h: br_take_q <= br_req && h_q == br_if_set;
                fl_i: br_take_q <= br_req && i_q == br_if_set;
                fl_n: br_take_q <= br_req && n_q == br_if_set;
                fl_z: br_take_q <= br_req && z_q == br_if_set;
                default: br_take_q <= br_req && c_q == br_if_set;
            endcase
        end
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_fixed_bits: assert property (cc_q[7:5] == CC_FIXED)
        else $error("fixed flag bits not one");
    a_neg_copy: assert property (alu.valid && idle |=>
        n_q == $past(alu.result[7]))
        else $error("negative flag not result bit 7");
    a_zero_flag: assert property (alu.valid && idle |=>
        z_q == ($past(alu.result) == 8'h00))
        else $error("zero flag wrong");
    a_irq_five: assert property (irq_take_q |=>
        stk_we_q [*5] ##1 !stk_we_q)
        else $error("interrupt frame not five bytes");
    a_irq_mask: assert property (irq_take_q |-> ##5 i_q)
        else $error("mask not set after entry");
    a_pcl_first: assert property (irq_take_q |=>
        stk_wdata_q == $past(pc_q[7:0]) && stk_addr_q == $past(sp_q))
        else $error("low pc byte not pushed first");
    a_y_kept: assert property (!idle |=> $stable(y_q))
        else $error("second index changed in frame");
    a_sp_reset: assert property (idle && flag_cmd.reset_sp |=>
        sp_q == {SP_UPPER, SP_LOW_RESET})
        else $error("stack pointer not at top");
    a_push_dec: assert property (stk_we_q |->
        sp_q == 16'(stk_addr_q - 16'h0001) || sp_q[6:0] == 7'h7f)
        else $error("pointer not decremented after push");
    a_pend_hold: assert property (pending_q && i_q |=> pending_q)
        else $error("masked request lost");

    c_irq_entry: cover property (irq_take_q ##5 i_q);
    c_interrupt_return_instruction: cover property (idle && cmd == cmd_interrupt_return_instruction ##1 !idle [*8]
        ##3 idle);
    c_call: cover property (idle && cmd == cmd_call);
    c_masked_pend: cover property (pending_q && i_q ##1 !i_q);

endmodule

// ---- core/cpu_regs_pkg.sv ----
// Constants, encodings and carriers shared by the CPU register file
package cpu_regs_pkg;

    // ========================================================
    // Condition flag layout
    localparam int CC_H = 4;
    localparam int CC_I = 3;
    localparam int CC_N = 2;
    localparam int CC_Z = 1;
    localparam int CC_C = 0;
    localparam logic [2:0] CC_FIXED = 3'h7;

    // ========================================================
    // Reset values
    localparam logic [7:0] A_RESET = 8'h00;
    localparam logic [7:0] X_RESET = 8'h00;
    localparam logic [7:0] Y_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b1;

    // ========================================================
    // Stack geometry: upper bits fixed, stack at top of work RAM
    localparam logic [8:0] SP_UPPER = 9'h003;
    localparam logic [6:0] SP_LOW_RESET = 7'h7f;
    localparam logic [2:0] IRQ_FRAME = 3'h5;
    localparam logic [2:0] CALL_FRAME = 3'h2;
    localparam logic [2:0] CC_FRAME = 3'h1;

    // ========================================================
    // Encodings
    typedef enum logic [2:0] {cmd_none, cmd_call, cmd_ret, cmd_trap,
        cmd_interrupt_return_instruction, cmd_push_cc, cmd_pop_cc} cmd_e;
    typedef enum logic [2:0] {fl_h, fl_i, fl_n, fl_z, fl_c} flag_sel_e;
    typedef enum logic [1:0] {k_irq, k_call, k_cc} kind_e;
    typedef enum logic [2:0] {b_pcl, b_pch, b_x, b_a, b_cc} byte_sel_e;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic is_add;
        logic with_carry;
        logic upd_c;
        logic carry;
        logic [7:0] opnd_a;
        logic [7:0] opnd_b;
        logic [7:0] result;
    } alu_s;

    typedef struct packed {
        logic a_en;
        logic idx_en;
        logic sp_en;
        logic pc_en;
        logic pc_inc;
        logic [7:0] data;
        logic [15:0] pc;
    } reg_wr_s;

    typedef struct packed {
        logic set_mask;
        logic reset_mask;
        logic set_carry;
        logic clear_carry;
        logic reset_sp;
    } flag_cmd_s;

endpackage

// ---- tb/tb_cpu_core_register_file.sv ----
// Self-checking bench for the CPU register file and stack sequencer
`timescale 1ns/1ps
module tb_cpu_core_register_file
    import cpu_regs_pkg::*;
    ;
    // ==========================================================
    // Stimulus and observed signals
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    reg_wr_s reg_wr = '0;
    alu_s alu = '0;
    flag_cmd_s flag_cmd = '0;
    cmd_e cmd = cmd_none;
    flag_sel_e br_flag = fl_h;
    logic prefix_second = 1'b0;
    logic instr_done = 1'b0;
    logic instr_boundary = 1'b0;
    logic irq_req = 1'b0;
    logic br_req = 1'b0;
    logic br_if_set = 1'b0;
    logic [7:0] stk_rdata;
    logic [7:0] a_q, x_q, y_q, index_q, cc_q, stk_wdata_q;
    logic [15:0] pc_q, sp_q, stk_addr_q;
    logic stk_we_q, stk_re_q, busy_q, br_valid_q, br_take_q;
    logic irq_take_q, pending_q;
    logic [7:0] mem [256];
    logic [15:0] qa [$];
    logic [7:0] qd [$];
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_rd = 0;
    logic exp_take;
    // Rows: add, with carry, update carry, carry, a, b, result, flags
    logic [35:0] rows [4] = '{
        {4'b1010, 8'h08, 8'h08, 8'h10, 8'hf8},
        {4'b1011, 8'h80, 8'h80, 8'h00, 8'heb},
        {4'b0000, 8'h00, 8'h00, 8'h80, 8'hed},
        {4'b1110, 8'h07, 8'h08, 8'h10, 8'hf8}};

    // ==========================================================
    // Clock, stack memory and watchdog
    always #4 clk_sys = ~clk_sys;

    // Read is combinational so popped bytes are ready in the strobe cycle
    assign stk_rdata = mem[stk_addr_q[7:0]];

    // Logged on the falling edge, away from the registered outputs
    always @(negedge clk_sys)
    begin
        if (stk_we_q === 1'b1)
        begin
            mem[stk_addr_q[7:0]] = stk_wdata_q;
            qa.push_back(stk_addr_q);
            qd.push_back(stk_wdata_q);
        end
        // Read strobes counted so pop length is checked on the port
        if (stk_re_q === 1'b1)
            n_rd++;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            $display("timeout after %0d cycles", cyc);
            final_report;
        end
    end

    cpu_core_register_file u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .alu(alu),
        .flag_cmd(flag_cmd), .cmd(cmd), .prefix_second(prefix_second),
        .instr_done(instr_done), .instr_boundary(instr_boundary),
        .irq_req(irq_req), .br_req(br_req), .br_flag(br_flag),
        .br_if_set(br_if_set), .stk_rdata(stk_rdata), .a_q(a_q),
        .x_q(x_q), .y_q(y_q), .index_q(index_q), .pc_q(pc_q),
        .cc_q(cc_q), .sp_q(sp_q), .stk_addr_q(stk_addr_q),
        .stk_wdata_q(stk_wdata_q), .stk_we_q(stk_we_q),
        .stk_re_q(stk_re_q), .busy_q(busy_q), .br_valid_q(br_valid_q),
        .br_take_q(br_take_q), .irq_take_q(irq_take_q),
        .pending_q(pending_q));

    // ==========================================================
    // Tasks
    task automatic final_report;
        $display("compared %0d, wrong %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    // Strobes drop on the edge that takes them, so each lasts one cycle
    // and the next request can be set without a zero-time glitch
    task automatic step;
        @(posedge clk_sys);
        reg_wr <= '0;
        alu <= '0;
        flag_cmd <= '0;
        cmd <= cmd_none;
        prefix_second <= 1'b0;
        instr_done <= 1'b0;
        br_req <= 1'b0;
        irq_req <= 1'b0;
        #1;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_q !== 1'b0 && n < 40)
        begin
            tick;
            n++;
        end
        chk_bit("frame ended", 1'b0, busy_q);
        // Last pushed byte is still on the port in the cycle that busy drops
        tick;
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq_take_q !== 1'b1 && n < 10)
        begin
            tick;
            n++;
        end
        chk_bit("irq taken", 1'b1, irq_take_q);
        wait_idle;
    endtask

    task automatic run_cmd(input cmd_e c);
        qa.delete();
        qd.delete();
        n_rd = 0;
        cmd = c;
        step;
        wait_idle;
    endtask

    // Expected bytes sit first-pushed in the highest of the n low bytes of ed
    task automatic chk_frame(input int n, input logic [15:0] a0,
                             input logic [39:0] ed);
        chk("frame bytes", 16'(n), 16'(qa.size()));
        for (int i = 0; i < n; i++)
        begin
            chk("push addr", {SP_UPPER, 7'(a0[6:0] - i)}, qa[i]);
            chk("push data", 16'(ed[8 * (n - 1 - i) +: 8]), 16'(qd[i]));
        end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        chk("flags", 16'h00e8, cc_q);
        chk("sp", 16'h01ff, sp_q);
        chk("a", 16'(A_RESET), a_q);
        chk("pc", PC_RESET, pc_q);
        $display("test reset done");
        reg_wr.a_en = 1'b1;
        reg_wr.data = 8'h5a;
        step;
        chk("a", 16'h005a, a_q);
        reg_wr.idx_en = 1'b1;
        reg_wr.data = 8'h33;
        step;
        chk("x", 16'h0033, x_q);
        prefix_second = 1'b1;
        step;
        reg_wr.idx_en = 1'b1;
        reg_wr.data = 8'h44;
        step;
        chk("y", 16'h0044, y_q);
        chk("x kept", 16'h0033, x_q);
        tick;
        chk("index y", 16'h0044, index_q);
        instr_done = 1'b1;
        step;
        tick;
        chk("index x", 16'h0033, index_q);
        reg_wr.pc_en = 1'b1;
        reg_wr.pc = 16'h1234;
        step;
        reg_wr.pc_inc = 1'b1;
        step;
        chk("pc", 16'h1235, pc_q);
        reg_wr.sp_en = 1'b1;
        reg_wr.data = 8'h85;
        step;
        chk("sp load", 16'h0185, sp_q);
        flag_cmd.reset_sp = 1'b1;
        step;
        chk("sp reset", 16'h01ff, sp_q);
        $display("test registers done");
        // Flag updates from the table
        for (int i = 0; i < 4; i++)
        begin
            {alu.is_add, alu.with_carry, alu.upd_c, alu.carry,
             alu.opnd_a, alu.opnd_b, alu.result} = rows[i][35:8];
            alu.valid = 1'b1;
            step;
            chk("flags", 16'(rows[i][7:0]), cc_q);
            chk_bit("half carry", rows[i][CC_H], cc_q[CC_H]);
            chk_bit("negative", rows[i][CC_N], cc_q[CC_N]);
            chk_bit("zero", rows[i][CC_Z], cc_q[CC_Z]);
            chk_bit("carry", rows[i][CC_C], cc_q[CC_C]);
        end
        // Every flag tested set and clear while flags are f8
        for (int f = 0; f < 5; f++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                br_flag = flag_sel_e'(f);
                br_if_set = s[0];
                br_req = 1'b1;
                step;
                chk_bit("br valid", 1'b1, br_valid_q);
                exp_take = 1'(8'hf8 >> (4 - f)) == s[0];
                chk_bit("br take", exp_take, br_take_q);
            end
        end
        $display("test flags done");
        flag_cmd.set_carry = 1'b1;
        step;
        chk("set carry", 16'h00f9, cc_q);
        flag_cmd.clear_carry = 1'b1;
        step;
        chk("clear carry", 16'h00f8, cc_q);
        flag_cmd.reset_mask = 1'b1;
        step;
        chk("unmask", 16'h00f0, cc_q);
        flag_cmd.set_mask = 1'b1;
        step;
        chk("mask", 16'h00f8, cc_q);
        flag_cmd.reset_mask = 1'b1;
        step;
        // Hardware interrupt frame
        qa.delete();
        qd.delete();
        instr_boundary = 1'b1;
        irq_req = 1'b1;
        step;
        wait_irq;
        chk_frame(5, 16'h01ff, 40'h3512335af0);
        chk("sp after irq", 16'h01fa, sp_q);
        chk("mask on entry", 16'h00f8, cc_q);
        chk("y untouched", 16'h0044, y_q);
        // A masked request waits
        irq_req = 1'b1;
        step;
        chk_bit("pending", 1'b1, pending_q);
        repeat (3) tick;
        chk_bit("no frame", 1'b0, busy_q);
        instr_boundary = 1'b0;
        reg_wr.a_en = 1'b1;
        reg_wr.data = 8'h00;
        step;
        reg_wr.idx_en = 1'b1;
        reg_wr.data = 8'h00;
        step;
        run_cmd(cmd_interrupt_return_instruction);
        chk("a restored", 16'h005a, a_q);
        chk("x restored", 16'h0033, x_q);
        chk("pc restored", 16'h1235, pc_q);
        chk("cc restored", 16'h00f0, cc_q);
        chk("sp restored", 16'h01ff, sp_q);
        chk("interrupt_return_instruction reads", 16'h0005, 16'(n_rd));
        qa.delete();
        qd.delete();
        instr_boundary = 1'b1;
        wait_irq;
        instr_boundary = 1'b0;
        chk_frame(5, 16'h01ff, 40'h3512335af0);
        $display("test interrupt done");
        // Trap runs while masked
        run_cmd(cmd_trap);
        chk("trap bytes", 16'h0005, 16'(qa.size()));
        chk("sp after trap", 16'h01f5, sp_q);
        run_cmd(cmd_push_cc);
        chk_frame(1, 16'h01f5, 40'hf8);
        chk("sp push", 16'h01f4, sp_q);
        flag_cmd.set_carry = 1'b1;
        step;
        run_cmd(cmd_pop_cc);
        chk("cc popped", 16'h00f8, cc_q);
        chk("sp pop", 16'h01f5, sp_q);
        chk("pop reads", 16'h0001, 16'(n_rd));
        $display("test trap done");
        // Call from the bottom of the stack wraps to the top
        reg_wr.sp_en = 1'b1;
        reg_wr.data = 8'h01;
        step;
        chk("sp load", 16'h0181, sp_q);
        reg_wr.pc_en = 1'b1;
        reg_wr.pc = 16'h2468;
        step;
        run_cmd(cmd_call);
        chk_frame(2, 16'h0181, 40'h6824);
        chk("sp wrap", 16'h01ff, sp_q);
        reg_wr.pc_en = 1'b1;
        reg_wr.pc = 16'h0abc;
        step;
        run_cmd(cmd_ret);
        chk("pc return", 16'h2468, pc_q);
        chk("sp unwrap", 16'h0181, sp_q);
        chk("ret reads", 16'h0002, 16'(n_rd));
        $display("test call done");
        // Reset again in mid-run
        resetn = 1'b0;
        tick;
        tick;
        resetn = 1'b1;
        chk("sp", 16'h01ff, sp_q);
        chk("flags", 16'h00e8, cc_q);
        $display("test second reset done");
        final_report;
    end
endmodule
